//--- core/wave_steer_top.sv
// Output steering, dead-band and blanking for a four-output waveform unit
// How it works
// (R1) Static level bits 7..4 for D,C,B,A
// (R2) Steer bit set: polarity-adjusted waveform drives output
// (R3) Steer bit clear: static level drives output
// (R4) Steering only while mode is 00x
// (R5) Rising event delays primary by rising dead-band
// (R6) Falling event delays complementary by falling dead-band
// (R7) Rising event blanks falling inputs for count
// (R8) Falling event blanks rising inputs for count
// (R9) Zero count means no delay, no blanking
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module wave_steer_top
    import wave_steer_pkg::*;
#(
    parameter int CHAIN_LEN = CHAIN_TICKS
)
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    // Events from the generator core
    input wire logic RISE_EVENT,
    input wire logic FALL_EVENT,
    // Generated waveforms for A..D before polarity
    input wire logic [NUM_OUT-1:0] WAVE_IN,
    // Outputs to the switching stage
    output logic OUTPUT_A,
    output logic OUTPUT_B,
    output logic OUTPUT_C,
    output logic OUTPUT_D,
    // Dead-banded primary and complementary drive
    output logic PRIMARY_OUT,
    output logic COMPLEMENT_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // State

    // All block state in one struct
    typedef struct packed
    {
        logic [7:0] steer;
        logic [CNT_W-1:0] db_rise;
        logic [CNT_W-1:0] db_fall;
        logic [CNT_W-1:0] blk_rise;
        logic [CNT_W-1:0] blk_fall;
        logic [7:0] control;
        logic [DATA_W-1:0] rdata;
        logic [NUM_OUT-1:0] outs;
        logic phase;
        logic prim;
        logic comp;
        logic [7:0] chain_cnt;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    // Counter handshakes
    logic dbr_busy, dbr_done, dbf_busy, dbf_done;
    logic blkr_busy, blkf_busy;
    logic rise_ok, fall_ok;
    logic chain_tick;
    logic rise_tick, fall_tick;
    logic steer_mode;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pads a six-bit count into a register byte; upper bits read zero
    function automatic logic [7:0] pad_count(input logic [CNT_W-1:0] v);
        pad_count = {{(8 - CNT_W){1'b0}}, v};
    endfunction

    // One output: waveform with polarity or static level
    function automatic logic steer_bit(input logic en, input logic lvl,
                                       input logic wav, input logic pol,
                                       input logic mode_ok);
        if (!mode_ok)
            steer_bit = wav ^ pol;
        else if (en)
            steer_bit = wav ^ pol; // see (R2)
        else
            steer_bit = lvl; // see (R3)
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event qualification

    // Blanking suppresses the opposite event
    assign rise_ok = RISE_EVENT && !blkf_busy; // see (R8)
    assign fall_ok = FALL_EVENT && !blkr_busy && !rise_ok; // see (R7)

    // Steering applies only for mode pattern 00x
    assign steer_mode = st_ff.control[CTL_MODE_LSB+1] == MODE_STEER_HI; // see (R4)

    // Delay-chain element pace; long chains trade accuracy for area
    assign chain_tick = st_ff.chain_cnt == 8'(CHAIN_LEN - 1);
    assign rise_tick = st_ff.control[CTL_RISING_DEADBAND_SOURCE_SELECT_BIT] ? chain_tick : 1'b1; // see (R5)
    assign fall_tick = st_ff.control[CTL_FALLING_DEADBAND_SOURCE_SELECT_BIT] ? chain_tick : 1'b1; // see (R6)

    ////////////////////////////////////////////////////////////////////////
    // Counters

    // Rising dead-band timer
    wave_delay_counter #(.W(CNT_W)) u_dbr
    (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .start(rise_ok),
        .count(st_ff.db_rise),
        .tick(rise_tick),
        .busy(dbr_busy),
        .done(dbr_done)
    );

    // Falling dead-band timer
    wave_delay_counter #(.W(CNT_W)) u_dbf
    (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .start(fall_ok),
        .count(st_ff.db_fall),
        .tick(fall_tick),
        .busy(dbf_busy),
        .done(dbf_done)
    );

    // Rising blanking timer in core clocks
    wave_delay_counter #(.W(CNT_W)) u_blkr
    (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .start(rise_ok),
        .count(st_ff.blk_rise),
        .tick(1'b1),
        .busy(blkr_busy),
        .done()
    );

    // Falling blanking timer in core clocks
    wave_delay_counter #(.W(CNT_W)) u_blkf
    (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .start(fall_ok),
        .count(st_ff.blk_fall),
        .tick(1'b1),
        .busy(blkf_busy),
        .done()
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Registers, dead-band outputs and steered outputs
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.chain_cnt = chain_tick ? 8'h00 : st_ff.chain_cnt + 8'h01;
        // Register writes
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                OFS_STEER: nxt_st.steer = REG_WDATA; // see (R1)
                OFS_DB_RISE: nxt_st.db_rise = REG_WDATA[CNT_W-1:0];
                OFS_DB_FALL: nxt_st.db_fall = REG_WDATA[CNT_W-1:0];
                OFS_BLK_RISE: nxt_st.blk_rise = REG_WDATA[CNT_W-1:0];
                OFS_BLK_FALL: nxt_st.blk_fall = REG_WDATA[CNT_W-1:0];
                OFS_CONTROL: nxt_st.control = REG_WDATA;
                default: ;
            endcase
        end
        // Register reads, data valid the next cycle; unmapped reads zero
        nxt_st.rdata = 8'h00;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                OFS_STEER: nxt_st.rdata = st_ff.steer;
                OFS_DB_RISE: nxt_st.rdata = pad_count(st_ff.db_rise);
                OFS_DB_FALL: nxt_st.rdata = pad_count(st_ff.db_fall);
                OFS_BLK_RISE: nxt_st.rdata = pad_count(st_ff.blk_rise);
                OFS_BLK_FALL: nxt_st.rdata = pad_count(st_ff.blk_fall);
                OFS_CONTROL: nxt_st.rdata = st_ff.control;
                OFS_STATUS: nxt_st.rdata = {2'b00, blkf_busy, blkr_busy,
                                            dbf_busy, dbr_busy, st_ff.comp, st_ff.prim};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // Events: both drives drop, the delayed one rises on done
        if (rise_ok)
        begin
            nxt_st.phase = 1'b1;
            nxt_st.comp = 1'b0;
            nxt_st.prim = 1'b0;
        end
        else if (fall_ok)
        begin
            nxt_st.phase = 1'b0;
            nxt_st.prim = 1'b0;
            nxt_st.comp = 1'b0;
        end
        else
        begin
            if (dbr_done && st_ff.phase)
                nxt_st.prim = 1'b1; // see (R5) (R9)
            if (dbf_done && !st_ff.phase)
                nxt_st.comp = 1'b1; // see (R6) (R9)
        end
        // Output steering per channel
        for (int i = 0; i < NUM_OUT; i++)
        begin
            nxt_st.outs[i] = steer_bit(st_ff.steer[STEER_LSB+i], st_ff.steer[LEVEL_LSB+i],
                                       WAVE_IN[i], st_ff.control[CTL_POL_LSB+i],
                                       steer_mode);
        end
    end

    // State register, synchronous reset
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESET_N)
        begin
            st_ff <= '0;
            st_ff.steer <= RST_STEER;
            st_ff.control <= RST_CONTROL;
            st_ff.db_rise <= RST_COUNT[CNT_W-1:0];
            st_ff.db_fall <= RST_COUNT[CNT_W-1:0];
            st_ff.blk_rise <= RST_COUNT[CNT_W-1:0];
            st_ff.blk_fall <= RST_COUNT[CNT_W-1:0];
        end
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from flip-flops
    assign REG_RDATA = st_ff.rdata;
    assign OUTPUT_A = st_ff.outs[0];
    assign OUTPUT_B = st_ff.outs[1];
    assign OUTPUT_C = st_ff.outs[2];
    assign OUTPUT_D = st_ff.outs[3];
    assign PRIMARY_OUT = st_ff.prim;
    assign COMPLEMENT_OUT = st_ff.comp;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Steering checks, one cycle after the inputs are sampled
    static_level_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R1)
        steer_mode && !st_ff.steer[STEER_LSB] |=> OUTPUT_A == $past(st_ff.steer[LEVEL_LSB]))
        else $error("static level not driven on A");

    steer_wave_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R2)
        steer_mode && st_ff.steer[STEER_LSB+3]
        |=> OUTPUT_D == ($past(WAVE_IN[3]) ^ $past(st_ff.control[CTL_POL_LSB+3])))
        else $error("steered D lacks polarity waveform");

    static_d_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R3)
        steer_mode && !st_ff.steer[STEER_LSB+3] |=> OUTPUT_D == $past(st_ff.steer[LEVEL_LSB+3]))
        else $error("static level not driven on D");

    mode_bypass_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R4)
        !steer_mode |=> OUTPUT_B == ($past(WAVE_IN[1]) ^ $past(st_ff.control[CTL_POL_LSB+1])))
        else $error("steering acted outside 00x mode");

    // Five clock dead-band: the register stage puts the primary up six edges on
    rise_delay_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R5)
        rise_ok && !st_ff.control[CTL_RISING_DEADBAND_SOURCE_SELECT_BIT] && st_ff.db_rise == 6'h05
        ##1 (!RISE_EVENT && !FALL_EVENT && !st_ff.control[CTL_RISING_DEADBAND_SOURCE_SELECT_BIT]) [*7]
        |-> PRIMARY_OUT)
        else $error("primary not raised after rising dead-band");

    fall_delay_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R6)
        fall_ok && !st_ff.control[CTL_FALLING_DEADBAND_SOURCE_SELECT_BIT] && st_ff.db_fall == 6'h05
        |=> !COMPLEMENT_OUT [*6])
        else $error("complementary rose before falling dead-band");

    // A blanked event must not pull down the drive that is up
    blank_fall_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R7)
        blkr_busy && FALL_EVENT && !RISE_EVENT |=> !$fell(PRIMARY_OUT))
        else $error("falling event passed during rising blanking");

    blank_rise_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R8)
        blkf_busy && RISE_EVENT && !FALL_EVENT |=> !$fell(COMPLEMENT_OUT))
        else $error("rising event passed during falling blanking");

    // Zero counts must add neither delay nor a blanking window
    zero_count_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R9)
        rise_ok && st_ff.db_rise == 6'h00 && st_ff.blk_rise == 6'h00
        |=> !blkr_busy ##1 (PRIMARY_OUT || $past(RISE_EVENT || FALL_EVENT)))
        else $error("zero count added delay");

    zero_fall_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R9)
        fall_ok && st_ff.db_fall == 6'h00 && st_ff.blk_fall == 6'h00
        |=> !blkf_busy ##1 (COMPLEMENT_OUT || $past(RISE_EVENT || FALL_EVENT)))
        else $error("zero falling count added delay");

    // Further steering checks on pins A and B
    // A and B sit in the low half of each field, C and D in the high half
    steered_first_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R2)
        steer_mode && st_ff.steer[STEER_LSB]
        |=> OUTPUT_A == ($past(WAVE_IN[0]) ^ $past(st_ff.control[CTL_POL_LSB])))
        else $error("steered A lacks polarity waveform");

    static_b_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R3)
        steer_mode && !st_ff.steer[STEER_LSB+1]
        |=> OUTPUT_B == $past(st_ff.steer[LEVEL_LSB+1]))
        else $error("static level not driven on B");

    // Any taken event drops both drives first, so the stage never sees a short
    rise_drop_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R5)
        rise_ok |=> !PRIMARY_OUT && !COMPLEMENT_OUT)
        else $error("drives not dropped after rising event");

    fall_drop_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R6)
        fall_ok |=> !PRIMARY_OUT && !COMPLEMENT_OUT)
        else $error("drives not dropped after falling event");

    // Both switches on at once would short the rail
    drive_overlap_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R6)
        !(PRIMARY_OUT && COMPLEMENT_OUT))
        else $error("primary and complementary drives overlap");

    // Unused upper bits of a count register always read back as zero
    count_pad_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see (R5)
        REG_RD && REG_ADDR == OFS_DB_RISE |=> REG_RDATA[DATA_W-1:CNT_W] == '0)
        else $error("count register upper bits not zero");

    // Scenario covers
    // Each main path of the block should be reached at least once

    rise_seen_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) rise_ok);
    fall_seen_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) fall_ok);
    blanked_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        FALL_EVENT && blkr_busy);
    static_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        steer_mode && st_ff.steer != 8'h00);
endmodule

//--- core/wave_steer_pkg.sv
// Constants, register map and field layout for the waveform steering block
package wave_steer_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets (8-bit registers, one per address)
    localparam logic [3:0] OFS_STEER = 4'h0;
    localparam logic [3:0] OFS_DB_RISE = 4'h1;
    localparam logic [3:0] OFS_DB_FALL = 4'h2;
    localparam logic [3:0] OFS_BLK_RISE = 4'h3;
    localparam logic [3:0] OFS_BLK_FALL = 4'h4;
    localparam logic [3:0] OFS_CONTROL = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;

    // Steering register fields
    localparam int STEER_LSB = 0;
    localparam int LEVEL_LSB = 4;
    localparam int NUM_OUT = 4;

    // Count fields
    localparam int CNT_W = 6;

    // Control register fields
    localparam int CTL_POL_LSB = 0;
    localparam int CTL_FALLING_DEADBAND_SOURCE_SELECT_BIT = 4;
    localparam int CTL_RISING_DEADBAND_SOURCE_SELECT_BIT = 5;
    localparam int CTL_MODE_LSB = 6;
    localparam int MODE_W = 2;

    // Reset values
    localparam logic [7:0] RST_STEER = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;

    // Mode pattern 00x: the upper mode bit must be clear
    localparam logic MODE_STEER_HI = 1'b0;

    // Delay-chain element default length in core clocks
    localparam int CHAIN_TICKS = 1;

endpackage

//--- core/wave_delay_counter.sv
// Down-counter for dead-band and blanking intervals
`timescale 1ns/1ps
module wave_delay_counter
    import wave_steer_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [W-1:0] count,
    input wire logic tick,
    // Status
    output logic busy,
    output logic done
);
    // All counter state
    typedef struct packed
    {
        logic [W-1:0] left;
        logic run;
        logic fin;
    } cnt_state_t;

    cnt_state_t cur_ff;
    cnt_state_t nxt_cur;

    // Next-state logic; a zero count finishes at once
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.fin = 1'b0;
        if (start)
        begin
            if (count == '0)
            begin
                // No extra periods for zero
                nxt_cur.run = 1'b0;
                nxt_cur.fin = 1'b1;
            end
            else
            begin
                nxt_cur.run = 1'b1;
                nxt_cur.left = count;
            end
        end
        else if (cur_ff.run && tick)
        begin
            if (cur_ff.left == W'(1))
            begin
                nxt_cur.run = 1'b0;
                nxt_cur.fin = 1'b1;
            end
            nxt_cur.left = cur_ff.left - W'(1);
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    assign busy = cur_ff.run;
    assign done = cur_ff.fin;

    // Covers for zero and nonzero starts
    zero_start_c: cover property (@(posedge clk) disable iff (!rst_n) start && count == '0);
    long_run_c: cover property (@(posedge clk) disable iff (!rst_n) cur_ff.run && tick);
endmodule

//--- verification/power_stage_model.sv
// Switching stage stand-in that watches the dead-banded drive pair
`timescale 1ns/1ps
module power_stage_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Gate drives from the block
    input wire logic high_gate,
    input wire logic low_gate,
    // Cycles with both switches on
    output int overlap_cycles
);
    ////////////////////////////////////////////////////////////////////////
    // Both switches on would short the rail, so every such cycle is counted
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            overlap_cycles <= 0;
        else if (high_gate === 1'b1 && low_gate === 1'b1)
            overlap_cycles <= overlap_cycles + 1;
    end
endmodule

//--- verification/wave_steer_top_tb.sv
// Self-checking bench for the steering, dead-band and blanking block
`timescale 1ns/1ps
module wave_steer_top_tb;
    import wave_steer_pkg::*;
    // Short chain element keeps chain-timed runs brief
    localparam int CHAIN = 3;
    // Stimulus and observed signals
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_RDATA;
    logic RISE_EVENT = 1'b0;
    logic FALL_EVENT = 1'b0;
    logic [3:0] WAVE_IN = 4'h0;
    logic OUTPUT_A, OUTPUT_B, OUTPUT_C, OUTPUT_D;
    logic PRIMARY_OUT, COMPLEMENT_OUT;
    // Bookkeeping
    int miscompares = 0;
    int n_tests = 0;
    int cnt, lo, hi, overlap;
    logic [7:0] counts [4] = '{8'h00, 8'h01, 8'h05, 8'h3F};
    // Control, steering, wave, expected outputs D..A
    logic [23:0] cases [7] = '{24'h000FAA, 24'h050FAF, 24'h00A05A, 24'h005304,
                               24'h40A05A, 24'h83A056, 24'hC0A055};

    ////////////////////////////////////////////////////////////////////////
    // Clock
    always #25 CORE_CLK = ~CORE_CLK;

    wave_steer_top #(.CHAIN_LEN(CHAIN)) wave_steer_top_i (.CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RISE_EVENT(RISE_EVENT),
        .FALL_EVENT(FALL_EVENT), .WAVE_IN(WAVE_IN), .OUTPUT_A(OUTPUT_A),
        .OUTPUT_B(OUTPUT_B), .OUTPUT_C(OUTPUT_C), .OUTPUT_D(OUTPUT_D),
        .PRIMARY_OUT(PRIMARY_OUT), .COMPLEMENT_OUT(COMPLEMENT_OUT));

    power_stage_model power_stage_model_i (.clk(CORE_CLK), .rst_n(RESET_N),
        .high_gate(PRIMARY_OUT), .low_gate(COMPLEMENT_OUT), .overlap_cycles(overlap));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask

    // One-cycle read; data is looked at in the following cycle only
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1;
        check(what, REG_RDATA, exp);
    endtask

    // One-cycle event pulse; returns at the edge that samples it
    task automatic fire(input logic r, input logic f);
        @(posedge CORE_CLK);
        RISE_EVENT <= r;
        FALL_EVENT <= f;
        @(posedge CORE_CLK);
        RISE_EVENT <= 1'b0;
        FALL_EVENT <= 1'b0;
    endtask

    // Edges until the chosen drive goes high, bounded
    task automatic wait_drive(input bit prim, output int n);
        n = 0;
        do
        begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        while ((prim ? PRIMARY_OUT : COMPLEMENT_OUT) !== 1'b1 && n < 400);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the eight hundred or so cycles the tests need
    initial
    begin
        #2000000;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        // Reset values, unused upper bits, unmapped place
        for (int a = 0; a < 7; a++)
            rd(a[3:0], 8'h00, "reset value");
        rd(4'hF, 8'h00, "unmapped read");
        wr(OFS_STEER, 8'h5A);
        rd(OFS_STEER, 8'h5A, "steering readback");
        for (int a = 1; a < 5; a++)
        begin
            wr(a[3:0], 8'hFF);
            rd(a[3:0], 8'h3F, "count readback");
            wr(a[3:0], 8'h00);
        end
        $display("test registers done");
        // Steering table across modes and polarities
        foreach (cases[i])
        begin
            wr(OFS_CONTROL, cases[i][23:16]);
            wr(OFS_STEER, cases[i][15:8]);
            WAVE_IN <= cases[i][7:4];
            repeat (3) @(posedge CORE_CLK);
            #1;
            check("outputs", {4'h0, OUTPUT_D, OUTPUT_C, OUTPUT_B, OUTPUT_A},
                  {4'h0, cases[i][3:0]});
        end
        $display("test steering done");
        // Dead-band in clocks and in chain elements, zero and full scale
        for (int s = 0; s < 2; s++)
            foreach (counts[i])
            begin
                wr(OFS_CONTROL, s ? 8'h30 : 8'h00);
                wr(OFS_DB_RISE, counts[i]);
                wr(OFS_DB_FALL, counts[i]);
                // Register stage adds one cycle; a chain element may start late
                lo = counts[i] + 1;
                if (s && counts[i] != 8'h00)
                    lo = (counts[i] - 1) * CHAIN + 2;
                hi = (s && counts[i] != 8'h00) ? lo + CHAIN - 1 : lo;
                fire(1'b1, 1'b0);
                wait_drive(1'b1, cnt);
                check("rise dead-band", 8'(cnt >= lo && cnt <= hi), 8'h01);
                check("complement held", {7'h00, COMPLEMENT_OUT}, 8'h00);
                fire(1'b0, 1'b1);
                wait_drive(1'b0, cnt);
                check("fall dead-band", 8'(cnt >= lo && cnt <= hi), 8'h01);
                check("primary held", {7'h00, PRIMARY_OUT}, 8'h00);
            end
        $display("test dead-band done");
        // Rising blanking hides an early falling event
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_DB_RISE, 8'h00);
        wr(OFS_DB_FALL, 8'h00);
        wr(OFS_BLK_RISE, 8'h06);
        fire(1'b1, 1'b0);
        fire(1'b0, 1'b1);
        repeat (8) @(posedge CORE_CLK);
        #1;
        check("fall blanked", {6'h00, PRIMARY_OUT, COMPLEMENT_OUT}, 8'h02);
        fire(1'b0, 1'b1);
        wait_drive(1'b0, cnt);
        check("fall after blank", 8'(cnt), 8'h01);
        // Falling blanking hides an early rising event
        wr(OFS_BLK_FALL, 8'h06);
        fire(1'b0, 1'b1);
        fire(1'b1, 1'b0);
        repeat (8) @(posedge CORE_CLK);
        #1;
        check("rise blanked", {6'h00, PRIMARY_OUT, COMPLEMENT_OUT}, 8'h01);
        // Zero blanking lets back-to-back events through
        wr(OFS_BLK_RISE, 8'h00);
        wr(OFS_BLK_FALL, 8'h00);
        fire(1'b1, 1'b0);
        fire(1'b0, 1'b1);
        wait_drive(1'b0, cnt);
        check("no blanking", 8'(cnt), 8'h01);
        // Complementary drive up, every timer idle
        rd(OFS_STATUS, 8'h02, "status drives");
        check("drive overlap", 8'(overlap), 8'h00);
        $display("test blanking done");
        finish_test();
    end
endmodule
